// ---- hdl/muc_user_channels.sv ----
/*
 * Two user command channels of a management serial controller and the frame
 * engine that runs them on one serial management bus.
 * Assumes a single synchronous register master and an external PHY bus whose
 * data line is resolved outside from the output enable.
 */
`timescale 1ns/1ns
module muc_user_channels #(
   // Three or more: the end-of-bit sample must see the synchronised line after the clock rise
   parameter int HALF_CYCLES = muc_pkg::MDC_HALF_CYCLES
) (
   input  wire logic        CLOCK,
   input  wire logic        RST_N,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   output logic             IRQ,
   output logic             MDC,
   output logic             MDIO_O,
   output logic             MDIO_OE,
   input  wire logic        MDIO_I
);

   typedef enum logic [1:0] {S_IDLE, S_RUN, S_DONE} muc_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   logic [31:0] cmd [2];
   logic        engine_enable;
   logic [1:0]  done_flag;
   logic [1:0]  done_mask;

   // Engine state
   muc_state_t  state;
   muc_state_t  next_state;
   logic        chan;
   logic [6:0]  bit_cnt;
   logic [7:0]  div_cnt;
   logic [63:0] shift_out;
   logic [15:0] shift_in;
   logic        ack_seen;

   // Serial input synchroniser flops
   logic        mdio_s1;
   logic        mdio_s2;

   function automatic logic [31:0] cmd_view(input logic [31:0] c);
      cmd_view = {c[31:29], 3'h0, c[25:0]};
   endfunction

   // Field extraction for the frame builder
   function automatic logic [4:0] reg_idx_of(input logic [31:0] c);
      reg_idx_of = c[muc_pkg::REG_IDX_LSB +: 5];
   endfunction

   function automatic logic [4:0] phy_sel_of(input logic [31:0] c);
      phy_sel_of = c[muc_pkg::PHY_SEL_LSB +: 5];
   endfunction

   function automatic logic [15:0] data_of(input logic [31:0] c);
      data_of = c[muc_pkg::DATA_LSB +: 16];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decode
   wire         hit_cmd0  = WR && ADDR == muc_pkg::OFS_CMD0;
   wire         hit_cmd1  = WR && ADDR == muc_pkg::OFS_CMD1;
   wire         hit_ctrl  = WR && ADDR == muc_pkg::OFS_CTRL;
   wire         hit_done  = WR && ADDR == muc_pkg::OFS_DONE;
   wire         hit_mset  = WR && ADDR == muc_pkg::OFS_MASK_SET;
   wire         hit_mclr  = WR && ADDR == muc_pkg::OFS_MASK_CLR;

   wire [1:0]   hit_cmd   = {hit_cmd1, hit_cmd0};
   wire [1:0]   launched  = {cmd[1][muc_pkg::BIT_LAUNCH], cmd[0][muc_pkg::BIT_LAUNCH]};

   wire         bit_tick  = div_cnt == 8'(2 * HALF_CYCLES - 1);
   // Sample at the end of each bit: the synchroniser then holds what the PHY drove after the clock rise
   wire         sample_pt = div_cnt == 8'(2 * HALF_CYCLES - 1);
   wire         frame_end = bit_tick && bit_cnt == 7'(muc_pkg::FRAME_BITS - 1);
   // Command fields cannot change while launched, so the running type is stable
   wire         is_write  = cmd[chan][muc_pkg::BIT_WRITE];
   // Completion pulse lasts exactly one cycle
   wire         finish    = state == S_DONE;
   wire [1:0]   fin_vec   = {finish && chan, finish && !chan};

   wire         pick      = launched[0] ? 1'b0 : 1'b1;
   wire [31:0]  sel_cmd   = cmd[pick];
   wire [1:0]   sel_op    = sel_cmd[muc_pkg::BIT_WRITE] ? muc_pkg::OP_WRITE : muc_pkg::OP_READ;
   wire [4:0]   sel_phy   = phy_sel_of(sel_cmd);
   wire [4:0]   sel_reg   = reg_idx_of(sel_cmd);
   wire [15:0]  sel_data  = data_of(sel_cmd);
   wire [63:0]  frame     = {32'hffff_ffff, 2'b01, sel_op, sel_phy, sel_reg, 2'b10, sel_data};
   wire [1:0]   masked    = done_flag & done_mask;

   // Write data with the reserved bits forced low before storage
   wire [30:0]  wr_fields = {WDATA[30:29], 3'h0, WDATA[25:0]};
   // Launch request counts only while the engine is enabled
   wire         set_launch = WDATA[muc_pkg::BIT_LAUNCH] && engine_enable;

   wire [1:0]   clr_done  = hit_done ? WDATA[1:0] : 2'h0;
   wire [1:0]   set_mask  = hit_mset ? WDATA[1:0] : 2'h0;
   wire [1:0]   clr_mask  = hit_mclr ? WDATA[1:0] : 2'h0;
   // Set wins over clear, so a completion is never lost to a racing clear
   wire [1:0]   next_done = (done_flag & ~clr_done) | fin_vec;
   wire [1:0]   next_mask = (done_mask | set_mask) & ~clr_mask;

   // Clock high in the second half of each bit and low whenever idle
   wire         next_mdc  = state == S_RUN && div_cnt >= 8'(HALF_CYCLES - 1) && !bit_tick;
   // Release the line from turnaround on reads so the PHY can drive
   wire         next_oe   = state == S_RUN && (is_write || bit_cnt < 7'(muc_pkg::TA_BIT));

   ////////////////////////////////////////////////////////////////////////////
   // Command registers
   // Identical channels
   for (genvar i = 0; i < 2; i++) begin : g_ch
      always_ff @(posedge CLOCK or negedge RST_N) begin
         if (!RST_N) begin
            cmd[i] <= muc_pkg::CMD_RESET;
         end else if (fin_vec[i]) begin
            cmd[i][muc_pkg::BIT_LAUNCH] <= 1'b0;
            if (!is_write) begin
               cmd[i][muc_pkg::BIT_ACK] <= ack_seen;
               if (ack_seen) begin
                  cmd[i][muc_pkg::DATA_LSB +: 16] <= shift_in;
               end
            end
         end else if (hit_cmd[i] && !launched[i]) begin
            cmd[i][30:0] <= wr_fields;
            if (set_launch) begin
               cmd[i][muc_pkg::BIT_LAUNCH] <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control, flags and mask
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         engine_enable <= muc_pkg::CTRL_RESET;
         done_flag     <= 2'h0;
         done_mask     <= 2'h0;
      end else begin
         if (hit_ctrl) begin
            engine_enable <= WDATA[muc_pkg::BIT_CTRL_ENABLE];
         end
         done_flag <= next_done;
         done_mask <= next_mask;
      end
   end

   assign IRQ = |masked;

   ////////////////////////////////////////////////////////////////////////////
   // Read port
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= 32'h0;
      end else if (RD) begin
         case (ADDR)
            muc_pkg::OFS_CMD0:     RDATA <= cmd_view(cmd[0]);
            muc_pkg::OFS_CMD1:     RDATA <= cmd_view(cmd[1]);
            muc_pkg::OFS_CTRL:     RDATA <= {31'h0, engine_enable};
            muc_pkg::OFS_DONE:     RDATA <= {30'h0, done_flag};
            muc_pkg::OFS_MASK_SET: RDATA <= {30'h0, done_mask};
            muc_pkg::OFS_MASK_CLR: RDATA <= {30'h0, done_mask};
            muc_pkg::OFS_MASKED:   RDATA <= {30'h0, masked};
            default:               RDATA <= 32'h0;
         endcase
      end else begin
         RDATA <= 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial input synchroniser
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         // Idle line is pulled high, so resetting to one avoids a false acknowledge
         mdio_s1 <= 1'b1;
         mdio_s2 <= 1'b1;
      end else begin
         mdio_s1 <= MDIO_I;
         mdio_s2 <= mdio_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Frame engine
   // Runs when bus free
   // Next state
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (|launched) begin
               next_state = S_RUN;
            end
         end
         S_RUN: begin
            if (frame_end) begin
               next_state = S_DONE;
            end
         end
         S_DONE: begin
            next_state = S_IDLE;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         state     <= S_IDLE;
         chan      <= 1'b0;
         bit_cnt   <= 7'h0;
         div_cnt   <= 8'h0;
         shift_out <= 64'h0;
         shift_in  <= 16'h0;
         ack_seen  <= 1'b0;
      end else begin
         state <= next_state;
         case (state)
            S_IDLE: begin
               div_cnt <= 8'h0;
               bit_cnt <= 7'h0;
               if (|launched) begin
                  chan      <= pick;
                  shift_out <= frame;
                  ack_seen  <= 1'b0;
               end
            end
            S_RUN: begin
               div_cnt <= bit_tick ? 8'h0 : div_cnt + 8'h1;
               // End-of-bit sample of the synchronised line
               if (sample_pt && !is_write) begin
                  if (bit_cnt == 7'(muc_pkg::TA_BIT + 1)) begin
                     ack_seen <= !mdio_s2;
                  end
                  if (bit_cnt > 7'(muc_pkg::TA_BIT + 1)) begin
                     shift_in <= {shift_in[14:0], mdio_s2};
                  end
               end
               if (bit_tick) begin
                  bit_cnt   <= bit_cnt + 7'h1;
                  shift_out <= {shift_out[62:0], 1'b1};
               end
            end
            default: begin
               div_cnt <= 8'h0;
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         MDC     <= 1'b0;
         MDIO_O  <= 1'b1;
         MDIO_OE <= 1'b0;
      end else begin
         MDC     <= next_mdc;
         MDIO_O  <= shift_out[63];
         MDIO_OE <= next_oe;
      end
   end

endmodule // muc_user_channels

// ---- shared/muc_pkg.sv ----
/*
 * Package for the user command channels of the management serial controller:
 * register offsets, field positions, reset values and frame timing.
 * Assumes a 20 MHz system clock and a register port with one-cycle read latency.
 */
package muc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CMD0      = 8'h00;
   localparam logic [7:0] OFS_CMD1      = 8'h04;
   localparam logic [7:0] OFS_CTRL      = 8'h08;
   localparam logic [7:0] OFS_DONE      = 8'h0c;
   localparam logic [7:0] OFS_MASK_SET  = 8'h10;
   localparam logic [7:0] OFS_MASK_CLR  = 8'h14;
   localparam logic [7:0] OFS_MASKED    = 8'h18;
   // Command and control register fields
   localparam int BIT_LAUNCH    = 31;
   localparam int BIT_WRITE     = 30;
   localparam int BIT_ACK       = 29;
   localparam int REG_IDX_LSB   = 21;
   localparam int PHY_SEL_LSB   = 16;
   localparam int DATA_LSB      = 0;
   localparam int BIT_CTRL_ENABLE = 0;
   // Reset values
   localparam logic [31:0] CMD_RESET  = 32'h0000_0000;
   localparam logic        CTRL_RESET = 1'b0;
   // Serial clock divider: half period of the management clock in system cycles
   localparam int MDC_HALF_CYCLES = 4;
   // Frame length in management clock periods
   localparam int FRAME_BITS = 64;
   localparam int TA_BIT     = 46;
   // Preamble plus header length in bits before turnaround
   localparam int HDR_BITS   = 32 + 14;
   localparam logic [1:0] OP_READ  = 2'b10;
   localparam logic [1:0] OP_WRITE = 2'b01;
endpackage

// ---- tb/muc_checker_sva.sv ----
/* Port checker for the user command channels.
   Assumes it is bound to the top design module. */
`timescale 1ns/1ns
module muc_checker #(
   parameter int HALF_CYCLES = 4
) (
   input wire logic        CLOCK,
   input wire logic        RST_N,
   input wire logic [7:0]  ADDR,
   input wire logic [31:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [31:0] RDATA,
   input wire logic        IRQ,
   input wire logic        MDC,
   input wire logic        MDIO_O,
   input wire logic        MDIO_OE
);
   localparam int RD_OE = 92 * HALF_CYCLES;
   localparam int WR_OE = 128 * HALF_CYCLES;
   logic [15:0] oe_cnt;
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N)
         oe_cnt <= 16'h0000;
      else
         oe_cnt <= MDIO_OE ? oe_cnt + 16'h0001 : 16'h0000;
   end
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   sequence preamble_s;
      MDIO_OE && MDIO_O;
   endsequence
   rsvd_zero_a: assert property ($past(RD) && $past(ADDR) inside {8'h00, 8'h04} |-> RDATA[28:26] == 3'h0)
      else $error("reserved command bits read nonzero");
   rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
      else $error("read data outside read cycle");
   preamble_ones_a: assert property ($rose(MDIO_OE) |-> preamble_s [*8])
      else $error("frame does not open with ones");
   frame_start_a: assert property ($rose(MDIO_OE) |-> !MDC)
      else $error("frame started with clock high");
   frame_len_a: assert property ($fell(MDIO_OE) |-> oe_cnt == RD_OE || oe_cnt == WR_OE)
      else $error("driven part of frame has wrong length");
   bus_release_a: assert property ($fell(MDIO_OE) |-> !MDIO_OE [*8])
      else $error("data line taken back too soon");
   mask_clear_a: assert property (WR && ADDR == 8'h14 && WDATA[1:0] == 2'b11 |=> !IRQ)
      else $error("interrupt stays up with both masks cleared");
   irq_cause_a: assert property ($rose(IRQ) |-> !MDIO_OE || $past(WR))
      else $error("interrupt rose without a cause");
endmodule // muc_checker

// ---- tb/muc_phy_model.sv ----
/* Behavioural PHY on the management bus: captures each frame, answers reads.
   Assumes the bench resolves the data line with a pull-up. */
`timescale 1ns/1ns
module muc_phy_model (
   input  wire logic        MDC,
   input  wire logic        MDIO_OE,
   input  wire logic        LINE,
   input  wire logic        ACK_EN,
   output logic             PHY_OE,
   output logic      [63:0] FRAME
);
   int          cnt = 65;
   logic        is_rd = 1'b0;
   logic [15:0] rdat = 16'h0000;
   initial FRAME = 64'h0;
   always @(posedge MDIO_OE) cnt = 0;
   always @(posedge MDC) begin
      FRAME = {FRAME[62:0], LINE};
      cnt = cnt + 1;
      if (cnt == 36) is_rd = (FRAME[1:0] == 2'b10);
      if (cnt == 46) rdat = 16'ha5c3 ^ {11'h000, FRAME[4:0]};
   end
   // Let go only after the last bit's high phase, so the sample point is covered
   always @(negedge MDC) if (cnt == 64) cnt = 65;
   assign PHY_OE = ACK_EN && is_rd && cnt >= 48 && cnt <= 64 && (cnt == 48 || !rdat[64 - cnt]);
endmodule // muc_phy_model

// ---- tb/tb.sv ----
/* Self-checking bench: register tasks drive the channels, a PHY model answers.
   Assumes package, design, checker and PHY model are compiled first. */
`timescale 1ns/1ns
module tb;
   logic        clock = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        ack_en = 1'b1;
   logic [31:0] rdata, v;
   logic        irq, mdc, mdio_o, mdio_oe, phy_oe;
   logic [63:0] frame;
   int          bad_count = 0;
   int          checks = 0;
   int          cyc = 0;
   wire         line = mdio_oe ? mdio_o : !phy_oe;
   always #25 clock = ~clock;
   muc_user_channels u_dut (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .IRQ(irq), .MDC(mdc), .MDIO_O(mdio_o), .MDIO_OE(mdio_oe), .MDIO_I(line));
   muc_phy_model u_phy (.MDC(mdc), .MDIO_OE(mdio_oe), .LINE(line), .ACK_EN(ack_en), .PHY_OE(phy_oe),
      .FRAME(frame));
   task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
         bad_count++;
      end
   endtask
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rd32(input logic [7:0] a);
      @(posedge clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wait_done(input logic [31:0] m);
      int n;
      n = 0;
      v = 32'h0;
      while ((v & m) !== m && n < 2000) begin
         rd32(muc_pkg::OFS_DONE);
         n++;
      end
      chk("done flags", v & m, m);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc++;
      if (cyc == 30000) begin
         bad_count++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (5) @(posedge clock);
      rst_n <= 1'b1;
      rd32(8'h1c);
      chk("unmapped", v, 32'h0);
      wr32(muc_pkg::OFS_CMD0, 32'h9c12_3456);
      rd32(muc_pkg::OFS_CMD0);
      chk("launch while off", v, 32'h0012_3456);
      wr32(muc_pkg::OFS_CTRL, 32'h1);
      wr32(muc_pkg::OFS_MASK_SET, 32'h3);
      wr32(muc_pkg::OFS_CMD0, 32'h40a9_beef);
      rd32(muc_pkg::OFS_CMD0);
      chk("launch zero write", v, 32'h40a9_beef);
      wr32(muc_pkg::OFS_CMD0, 32'hc0a9_beef);
      wr32(muc_pkg::OFS_CMD0, 32'h0000_1111);
      rd32(muc_pkg::OFS_CMD0);
      chk("write while busy", v, 32'hc0a9_beef);
      wait_done(32'h1);
      rd32(muc_pkg::OFS_CMD0);
      chk("launch cleared", v, 32'h40a9_beef);
      chk("write frame", frame, 64'hffff_ffff_5496_beef);
      chk("irq up", irq, 1'b1);
      wr32(muc_pkg::OFS_MASK_CLR, 32'h1);
      chk("irq masked", irq, 1'b0);
      wr32(muc_pkg::OFS_MASK_SET, 32'h0);
      chk("mask set zero", irq, 1'b0);
      wr32(muc_pkg::OFS_MASK_SET, 32'h1);
      rd32(muc_pkg::OFS_MASKED);
      chk("masked status", v, 32'h1);
      wr32(muc_pkg::OFS_DONE, 32'h1);
      chk("irq cleared", irq, 1'b0);
      wr32(muc_pkg::OFS_CMD0, 32'h80e1_0000);
      wr32(muc_pkg::OFS_CMD1, 32'h8062_0000);
      rd32(muc_pkg::OFS_CMD1);
      chk("ch1 waits", v, 32'h8062_0000);
      wait_done(32'h1);
      rd32(muc_pkg::OFS_DONE);
      chk("ch0 first", v, 32'h1);
      wait_done(32'h3);
      rd32(muc_pkg::OFS_CMD0);
      chk("read ch0", v, 32'h20e1_a5c4);
      rd32(muc_pkg::OFS_CMD1);
      chk("read ch1", v, 32'h2062_a5c0);
      wr32(muc_pkg::OFS_DONE, 32'h3);
      ack_en <= 1'b0;
      wr32(muc_pkg::OFS_CMD0, 32'h80e1_0000);
      wait_done(32'h1);
      rd32(muc_pkg::OFS_CMD0);
      chk("no ack", v, 32'h00e1_0000);
      tally_and_finish;
   end
endmodule // tb
bind muc_user_channels muc_checker #(.HALF_CYCLES(HALF_CYCLES)) u_chk (.CLOCK(CLOCK), .RST_N(RST_N),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .MDC(MDC), .MDIO_O(MDIO_O),
   .MDIO_OE(MDIO_OE));
